// ### src/muovr_top.sv
// Override and override-request logic of the muting function, with APB registers.
// Assumes the muting core on the same clock supplies its status pulses and levels.
//
// How it works
// - Request blinks 2 Hz when muting off, a sensor on, guard blocked, enable off.
// - A qualified override pulse during a request raises the output enable.
// - Override pulses held longer than 3 s are ignored.
// - Override ends once sensors clear and guard outputs are on again.
// - No grant once the override budget is spent.
// - Budget is sixty minutes over the total muting time.
// - Total muting time of 1 to 10 s gives 360 overrides.
// - 15 minutes or more, or check disabled, gives 5 overrides.
// - Override counter steps when a request episode starts.
// - Counter clears on valid muting end, reset, idle to executing.
// - Pulse after blinking request restarts muting via the enable.
// - Faulty-sensor stop gives a one-scan request when conditions hold.
// - A repeated sensor fault stops again and requests again.
// - During override, direction, sequence and concurrency checks are skipped.
// - Conveyor stopped holds the muting timers.
// - Conveyor restart resumes timers with three extra seconds.
// - Status is one during clean override, zero on muting error.
// - Zero total muting time disables duration supervision.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module muovr_top #(
    parameter int SCAN_CYCLES = muovr_pkg::SCAN_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [muovr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] muteSensor,
    input wire logic protectiveDeviceSafeOutput,
    input wire logic overrideIn,
    input wire logic conveyorRun,
    input wire logic execMode,
    input wire logic mutingActive,
    input wire logic mutingValidEnd,
    input wire logic mutingFaultStop,
    input wire logic mutingError,
    output logic overrideRequest,
    output logic outputEnable,
    output logic overrideActive,
    output logic mutingStatus,
    output logic timersHold,
    output logic mutingTimeout,
    output logic overrideExhausted
);
    typedef struct packed {
        logic [muovr_pkg::PIN_W-1:0] sync1;
        logic [muovr_pkg::PIN_W-1:0] sync2;
        logic execPrev;
        logic convPrev;
        logic [muovr_pkg::SCAN_W-1:0] scanCnt;
        logic tick;
        logic [muovr_pkg::BLINK_W-1:0] blinkCnt;
        logic blinkPhase;
        logic reqPrev;
        logic faultReq;
        logic reqOut;
        logic ovrActive;
        logic mstat;
        logic timeout;
        logic [muovr_pkg::COUNT_W-1:0] count;
        logic [muovr_pkg::TIMER_W-1:0] elapsed;
        logic [muovr_pkg::TIMER_W-1:0] credit;
        logic [muovr_pkg::SEC_W-1:0] ctrlSec;
        logic ctrlCheck;
        logic [31:0] rdata;
        logic err;
    } muovr_top_t;

    muovr_top_t q;
    muovr_top_t d;
    logic [1:0] rstSync_q;
    logic rstSyncN;
    muovr_link_if lnk ();

    logic [3:0] sensors;
    logic safeOk;
    logic convRun;
    logic reqCond;
    logic reqRise;
    logic clrEvt;
    logic exhausted;
    logic act;
    logic setup;
    logic access;
    logic mapped;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync_q[1];

    muovr_pulse_qual uQual (
        .clk(clk),
        .rstn(rstSyncN),
        .lnk(lnk.qual)
    );

    muovr_limit uLimit (
        .clk(clk),
        .rstn(rstSyncN),
        .lnk(lnk.lim)
    );

    assign sensors = q.sync2[3:0];
    assign safeOk = q.sync2[muovr_pkg::PIN_SAFE];
    assign convRun = q.sync2[muovr_pkg::PIN_CONV];
    assign act = mutingActive || q.ovrActive;
    assign reqCond = !q.mstat && (sensors != 4'h0) && !safeOk && !q.ovrActive;
    assign reqRise = reqCond && !q.reqPrev;
    assign clrEvt = mutingValidEnd || (q.sync2[muovr_pkg::PIN_EXEC] && !q.execPrev);
    assign exhausted = q.count > lnk.limit;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == muovr_pkg::CTRL_ADDR) || (paddr == muovr_pkg::STATUS_ADDR)
        || (paddr == muovr_pkg::COUNT_ADDR);

    assign lnk.tick = q.tick;
    assign lnk.ovrLevel = q.sync2[muovr_pkg::PIN_OVR];
    assign lnk.arm = reqCond && !exhausted;
    assign lnk.totalSec = q.ctrlSec;
    assign lnk.checkEn = q.ctrlCheck;

    always_comb begin
        d = q;
        // Pin synchronisers
        d.sync1 = {execMode, conveyorRun, overrideIn, protectiveDeviceSafeOutput, muteSensor};
        d.sync2 = q.sync1;
        d.execPrev = q.sync2[muovr_pkg::PIN_EXEC];
        d.convPrev = convRun;
        d.reqPrev = reqCond;
        // Scan divider
        d.tick = 1'b0;
        if (q.scanCnt == muovr_pkg::SCAN_W'(SCAN_CYCLES - 1)) begin
            d.scanCnt = '0;
            d.tick = 1'b1;
        end else begin
            d.scanCnt = q.scanCnt + 1'b1;
        end
        // Request blink, starts in the lit half
        if (!reqCond) begin
            d.blinkCnt = '0;
            d.blinkPhase = 1'b1;
        end else if (q.tick) begin
            if (q.blinkCnt == muovr_pkg::BLINK_W'(muovr_pkg::BLINK_HALF_SCANS - 1)) begin
                d.blinkCnt = '0;
                d.blinkPhase = !q.blinkPhase;
            end else begin
                d.blinkCnt = q.blinkCnt + 1'b1;
            end
        end
        // One-scan request after a faulty-sensor stop
        if (mutingFaultStop) begin
            d.faultReq = 1'b1;
        end else if (q.tick) begin
            d.faultReq = 1'b0;
        end
        d.reqOut = reqCond && (d.blinkPhase || d.faultReq);
        // Override cycle counter, a new episode outranks a clear
        if (clrEvt) begin
            d.count = reqRise ? muovr_pkg::COUNT_W'(1) : '0;
        end else if (reqRise && q.count != muovr_pkg::COUNT_MAX) begin
            d.count = q.count + 1'b1;
        end
        // Override state, grant outranks release
        if (lnk.grant) begin
            d.ovrActive = 1'b1;
        end else if (sensors == 4'h0 && safeOk) begin
            d.ovrActive = 1'b0;
        end
        d.mstat = (mutingActive || d.ovrActive) && !mutingError;
        // Total muting timer, a restart adds extra time as credit, credit kept unchanged if the sum would overflow
        if (!act) begin
            d.elapsed = '0;
            d.credit = '0;
        end else if (convRun && !q.convPrev) begin
            if (q.credit <= ~muovr_pkg::RESUME_BONUS_SCANS) begin
                d.credit = q.credit + muovr_pkg::RESUME_BONUS_SCANS;
            end
        end else if (q.tick && convRun && !q.timeout) begin
            d.elapsed = q.elapsed + 1'b1;
        end
        d.timeout = act && q.ctrlCheck && (q.ctrlSec != '0)
            && ({1'b0, q.elapsed} >= {1'b0, muovr_pkg::TIMER_W'(q.ctrlSec)
                * muovr_pkg::TIMER_W'(muovr_pkg::SCANS_PER_SEC)} + {1'b0, q.credit});
        // APB: data captured in setup, write taken in access
        if (setup) begin
            d.err = !mapped;
            d.rdata = 32'h0000_0000;
            case (paddr)
                muovr_pkg::CTRL_ADDR: begin
                    d.rdata[muovr_pkg::SEC_W-1:0] = q.ctrlSec;
                    d.rdata[muovr_pkg::CTRL_CHECK_BIT] = q.ctrlCheck;
                end
                muovr_pkg::STATUS_ADDR: begin
                    d.rdata[muovr_pkg::ST_REQ] = q.reqOut;
                    d.rdata[muovr_pkg::ST_OEN] = q.ovrActive;
                    d.rdata[muovr_pkg::ST_OVR] = q.ovrActive;
                    d.rdata[muovr_pkg::ST_MSTAT] = q.mstat;
                    d.rdata[muovr_pkg::ST_TIMEOUT] = q.timeout;
                    d.rdata[muovr_pkg::ST_HOLD] = !convRun;
                    d.rdata[muovr_pkg::ST_EXHAUST] = exhausted;
                    d.rdata[muovr_pkg::ST_TOOLONG] = lnk.tooLong;
                end
                muovr_pkg::COUNT_ADDR: begin
                    d.rdata[muovr_pkg::COUNT_W-1:0] = q.count;
                    d.rdata[muovr_pkg::COUNT_LIMIT_LSB +: muovr_pkg::COUNT_W] = lnk.limit;
                end
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        if (access && pwrite && paddr == muovr_pkg::CTRL_ADDR) begin
            d.ctrlSec = pwdata[muovr_pkg::SEC_W-1:0];
            d.ctrlCheck = pwdata[muovr_pkg::CTRL_CHECK_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            q <= '{sync1: '0, sync2: '0, execPrev: 1'b0, convPrev: 1'b0, scanCnt: '0,
                tick: 1'b0, blinkCnt: '0, blinkPhase: 1'b1, reqPrev: 1'b0, faultReq: 1'b0,
                reqOut: 1'b0, ovrActive: 1'b0, mstat: 1'b0, timeout: 1'b0, count: '0,
                elapsed: '0, credit: '0, ctrlSec: muovr_pkg::CTRL_SEC_RESET,
                ctrlCheck: muovr_pkg::CTRL_CHECK_RESET, rdata: 32'h0000_0000, err: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = access && q.err;
    assign overrideRequest = q.reqOut;
    assign outputEnable = q.ovrActive;
    assign overrideActive = q.ovrActive;
    assign mutingStatus = q.mstat;
    assign timersHold = !convRun;
    assign mutingTimeout = q.timeout;
    assign overrideExhausted = exhausted;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstSyncN);

    chk_req_conditions: assert property (q.reqOut |-> $past(reqCond))
        else $error("Override request raised without its conditions");
    chk_count_step: assert property (
        reqRise && !clrEvt && q.count != muovr_pkg::COUNT_MAX |=> q.count == $past(q.count) + 1'b1)
        else $error("Override counter did not step on a new request");
    chk_count_clear: assert property (clrEvt && !reqRise |=> q.count == '0)
        else $error("Override counter not cleared");
    chk_grant_enable: assert property (lnk.grant |=> outputEnable ##1 outputEnable || !reqCond)
        else $error("Grant did not raise the output enable");
    chk_grant_budget: assert property (lnk.grant |-> !$past(exhausted))
        else $error("Override granted past the budget");
    chk_ovr_release: assert property (
        q.ovrActive && sensors == 4'h0 && safeOk && !lnk.grant |=> !q.ovrActive)
        else $error("Override not released after the field cleared");
    chk_status_error: assert property (mutingError |=> !mutingStatus || !$past(mutingError))
        else $error("Muting status high during a muting error");
    chk_timer_hold: assert property (
        act && !convRun && !q.convPrev ##1 act && !convRun |-> $stable(q.elapsed))
        else $error("Muting timer ran while the conveyor stood");
    chk_resume_bonus: assert property (
        act && convRun && !q.convPrev && q.credit <= ~muovr_pkg::RESUME_BONUS_SCANS
            |=> q.credit == $past(q.credit) + muovr_pkg::RESUME_BONUS_SCANS)
        else $error("Conveyor restart did not credit the timer");
    chk_timer_off: assert property (q.ctrlSec == '0 |=> !mutingTimeout)
        else $error("Duration supervision active with zero setting");

    // Request, enable, status, timer and counter checks
    chk_req_start: assert property (reqRise |=> overrideRequest)
        else $error("Request did not start lit");
    chk_req_off: assert property (!reqCond |=> !overrideRequest)
        else $error("Request shown without its conditions");
    chk_req_enabled: assert property (outputEnable && $past(outputEnable) |-> !overrideRequest)
        else $error("Request shown while enabled");
    chk_fault_request: assert property (mutingFaultStop && reqCond |=> overrideRequest)
        else $error("Fault stop gave no request");
    chk_fault_clear: assert property (q.faultReq && q.tick && !mutingFaultStop |=> !q.faultReq)
        else $error("Fault request outlived its scan");
    chk_enable_hold: assert property (q.ovrActive && !(sensors == 4'h0 && safeOk) |=> q.ovrActive)
        else $error("Override dropped early");
    chk_status_override: assert property (q.ovrActive && !$past(mutingError) |-> mutingStatus)
        else $error("Status low during clean override");
    chk_timer_clear: assert property (!act |=> q.elapsed == '0 && q.credit == '0)
        else $error("Muting timer not cleared");
    chk_count_hold: assert property (!reqRise && !clrEvt |=> $stable(q.count))
        else $error("Override counter moved without cause");
    chk_long_pulse: assert property (lnk.tooLong |-> !lnk.grant)
        else $error("Grant during a too long pulse");
endmodule // muovr_top

// ### src/muovr_pkg.sv
// Constants, field layouts and types of the muting override block.
// Assumes a 250 MHz clock and a 1 ms controller scan.
package muovr_pkg;
    // Clock and scan timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCAN_PERIOD_US = 1000;
    localparam int SCAN_CYCLES = SCAN_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int SCAN_MS = SCAN_PERIOD_US / 1000;
    localparam int SCAN_W = 20;
    // Override pulse window, least time rounds up, longest rounds down
    localparam int OVR_MIN_MS = 100;
    localparam int OVR_MAX_MS = 3000;
    localparam int OVR_MIN_SCANS = (OVR_MIN_MS + SCAN_MS - 1) / SCAN_MS;
    localparam int OVR_MAX_SCANS = OVR_MAX_MS / SCAN_MS;
    localparam int OVR_CNT_W = 12;
    // Request blink
    localparam int BLINK_HZ = 2;
    localparam int BLINK_HALF_MS = 1000 / (2 * BLINK_HZ);
    localparam int BLINK_HALF_SCANS = BLINK_HALF_MS / SCAN_MS;
    localparam int BLINK_W = 9;
    // Total muting timer
    localparam int SCANS_PER_SEC = 1000 / SCAN_MS;
    localparam int RESUME_BONUS_S = 3;
    localparam int TIMER_W = 22;
    localparam logic [TIMER_W-1:0] RESUME_BONUS_SCANS = TIMER_W'(RESUME_BONUS_S * SCANS_PER_SEC);
    // Override budget
    localparam int SEC_W = 12;
    localparam int COUNT_W = 9;
    localparam logic [SEC_W-1:0] HOUR_S = 12'hE10;
    localparam logic [SEC_W-1:0] SHORT_TMT_S = 12'h00A;
    localparam logic [SEC_W-1:0] LONG_TMT_S = 12'h384;
    localparam logic [COUNT_W-1:0] SHORT_LIMIT = 9'h168;
    localparam logic [COUNT_W-1:0] LONG_LIMIT = 9'h005;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 9'h1FF;
    // Pin bundle positions
    localparam int PIN_W = 8;
    localparam int PIN_SAFE = 4;
    localparam int PIN_OVR = 5;
    localparam int PIN_CONV = 6;
    localparam int PIN_EXEC = 7;
    // APB map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 8'h08;
    localparam int CTRL_CHECK_BIT = 16;
    localparam logic [SEC_W-1:0] CTRL_SEC_RESET = 12'h005;
    localparam logic CTRL_CHECK_RESET = 1'b1;
    localparam int ST_REQ = 0;
    localparam int ST_OEN = 1;
    localparam int ST_OVR = 2;
    localparam int ST_MSTAT = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_HOLD = 5;
    localparam int ST_EXHAUST = 6;
    localparam int ST_TOOLONG = 7;
    localparam int COUNT_LIMIT_LSB = 16;

    typedef enum logic [1:0] {
        QS_IDLE = 2'b00,
        QS_HIGH = 2'b01,
        QS_LONG = 2'b11
    } muovr_qstate_t;
endpackage

// ### src/muovr_link_if.sv
// Carrier between the override top and its two helpers.
// Assumes all parties run on the same clock.
`timescale 1ns/100ps
interface muovr_link_if;
    logic tick;
    logic ovrLevel;
    logic arm;
    logic grant;
    logic tooLong;
    logic [muovr_pkg::SEC_W-1:0] totalSec;
    logic checkEn;
    logic [muovr_pkg::COUNT_W-1:0] limit;
    modport top (output tick, ovrLevel, arm, totalSec, checkEn, input grant, tooLong, limit);
    modport qual (input tick, ovrLevel, arm, output grant, tooLong);
    modport lim (input totalSec, checkEn, output limit);
endinterface

// ### src/muovr_pulse_qual.sv
// Override pushbutton pulse qualifier, width measured in scans.
// Assumes a synchronised override level and a one-cycle scan tick.
`timescale 1ns/100ps
module muovr_pulse_qual (
    input wire logic clk,
    input wire logic rstn,
    muovr_link_if.qual lnk
);
    typedef struct packed {
        muovr_pkg::muovr_qstate_t st;
        logic [muovr_pkg::OVR_CNT_W-1:0] cnt;
        logic grant;
    } muovr_qual_t;

    muovr_qual_t q;
    muovr_qual_t d;

    always_comb begin
        d = q;
        d.grant = 1'b0;
        case (q.st)
            muovr_pkg::QS_IDLE: begin
                if (lnk.ovrLevel) begin
                    d.st = muovr_pkg::QS_HIGH;
                    d.cnt = '0;
                end
            end
            muovr_pkg::QS_HIGH: begin
                if (!lnk.ovrLevel) begin
                    d.st = muovr_pkg::QS_IDLE;
                    d.grant = lnk.arm
                        && (q.cnt >= muovr_pkg::OVR_CNT_W'(muovr_pkg::OVR_MIN_SCANS))
                        && (q.cnt <= muovr_pkg::OVR_CNT_W'(muovr_pkg::OVR_MAX_SCANS));
                end else if (lnk.tick) begin
                    if (q.cnt >= muovr_pkg::OVR_CNT_W'(muovr_pkg::OVR_MAX_SCANS)) begin
                        d.st = muovr_pkg::QS_LONG;
                    end else begin
                        d.cnt = q.cnt + 1'b1;
                    end
                end
            end
            muovr_pkg::QS_LONG: begin
                if (!lnk.ovrLevel) begin
                    d.st = muovr_pkg::QS_IDLE;
                end
            end
            default: d.st = muovr_pkg::QS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: muovr_pkg::QS_IDLE, cnt: '0, grant: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign lnk.grant = q.grant;
    assign lnk.tooLong = (q.st == muovr_pkg::QS_LONG);

    chk_grant_width: assert property (@(posedge clk) disable iff (!rstn)
        q.grant |-> ($past(q.cnt) >= muovr_pkg::OVR_CNT_W'(muovr_pkg::OVR_MIN_SCANS))
            && ($past(q.cnt) <= muovr_pkg::OVR_CNT_W'(muovr_pkg::OVR_MAX_SCANS)))
        else $error("Override granted for a pulse outside its width window");
endmodule // muovr_pulse_qual

// ### src/muovr_limit.sv
// Override budget derived from the total muting time setting.
// Assumes the setting changes only rarely, from the register file.
`timescale 1ns/100ps
module muovr_limit (
    input wire logic clk,
    input wire logic rstn,
    muovr_link_if.lim lnk
);
    typedef struct packed {
        logic [muovr_pkg::COUNT_W-1:0] limit;
    } muovr_lim_t;

    muovr_lim_t q;
    muovr_lim_t d;

    always_comb begin
        d = q;
        if (!lnk.checkEn || lnk.totalSec == '0 || lnk.totalSec >= muovr_pkg::LONG_TMT_S) begin
            d.limit = muovr_pkg::LONG_LIMIT;
        end else if (lnk.totalSec <= muovr_pkg::SHORT_TMT_S) begin
            d.limit = muovr_pkg::SHORT_LIMIT;
        end else begin
            d.limit = muovr_pkg::COUNT_W'(muovr_pkg::HOUR_S / lnk.totalSec);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{limit: muovr_pkg::LONG_LIMIT};
        end else begin
            q <= d;
        end
    end

    assign lnk.limit = q.limit;

    chk_short_limit: assert property (@(posedge clk) disable iff (!rstn)
        (lnk.checkEn && lnk.totalSec != '0 && lnk.totalSec <= muovr_pkg::SHORT_TMT_S)
            ##1 $stable(lnk.totalSec) && $stable(lnk.checkEn) |-> q.limit == muovr_pkg::SHORT_LIMIT)
        else $error("Short muting time does not give the short budget");
    chk_long_limit: assert property (@(posedge clk) disable iff (!rstn)
        (!lnk.checkEn || lnk.totalSec >= muovr_pkg::LONG_TMT_S) |=> q.limit == muovr_pkg::LONG_LIMIT)
        else $error("Long or disabled muting time does not give the long budget");
endmodule // muovr_limit

// ### bench/muovr_partner.sv
// Far-side model: muting sensors, guard safe outputs, override button, conveyor.
// Assumes the bench calls its tasks from one process, on clk.
`timescale 1ns/100ps
module muovr_partner (
    input wire logic clk,
    output logic [3:0] muteSensor,
    output logic protectiveDeviceSafeOutput,
    output logic overrideIn,
    output logic conveyorRun
);
    initial begin
        muteSensor = 4'h0;
        protectiveDeviceSafeOutput = 1'b1;
        overrideIn = 1'b0;
        conveyorRun = 1'b1;
    end
    // Object enters: sensors active, field blocked
    task automatic objectIn(input logic [3:0] s);
        @(posedge clk);
        muteSensor <= s;
        protectiveDeviceSafeOutput <= 1'b0;
    endtask
    // Object leaves: sensors inactive, field clear
    task automatic objectOut();
        @(posedge clk);
        muteSensor <= 4'h0;
        protectiveDeviceSafeOutput <= 1'b1;
    endtask
    // Clean level pulse, no test pulses on the input
    task automatic press(input int scans, input int scanCycles);
        @(posedge clk);
        overrideIn <= 1'b1;
        repeat (scans * scanCycles) @(posedge clk);
        overrideIn <= 1'b0;
    endtask
    // Low while the conveyor stands
    task automatic conveyor(input logic run);
        @(posedge clk);
        conveyorRun <= run;
    endtask
endmodule // muovr_partner

// ### bench/testbench.sv
// Self-checking bench of the muting override block.
// Assumes the far-side model and a scan shortened to four clocks.
`timescale 1ns/100ps
module testbench;
    localparam int SC = 4;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [muovr_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] muteSensor;
    logic protectiveDeviceSafeOutput, overrideIn, conveyorRun;
    logic execMode, mutingActive, mutingValidEnd, mutingFaultStop, mutingError;
    logic overrideRequest, outputEnable, overrideActive, mutingStatus;
    logic timersHold, mutingTimeout, overrideExhausted;
    int err_total, checks, seed, n, i;
    int secs[11] = '{5, 10, 20, 30, 60, 300, 899, 900, 3600, 0, 60};

    muovr_top #(.SCAN_CYCLES(SC)) dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .muteSensor, .protectiveDeviceSafeOutput,
        .overrideIn, .conveyorRun, .execMode, .mutingActive, .mutingValidEnd,
        .mutingFaultStop, .mutingError, .overrideRequest, .outputEnable, .overrideActive,
        .mutingStatus, .timersHold, .mutingTimeout, .overrideExhausted);
    muovr_partner pm (.clk, .muteSensor, .protectiveDeviceSafeOutput, .overrideIn,
        .conveyorRun);

    function automatic logic [8:0] expLimit(input int s, input logic en);
        if (!en || s == 0 || s >= 900) return 9'h005;
        if (s <= 10) return 9'h168;
        return 9'(3600 / s);
    endfunction

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic cmpBit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wrap_up();
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        wrap_up();
    end

    initial begin
        seed = 32'hd14e;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        execMode = 1'b1;
        mutingActive = 1'b0;
        mutingValidEnd = 1'b0;
        mutingFaultStop = 1'b0;
        mutingError = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b0, muovr_pkg::CTRL_ADDR, 32'h0000_0000);
        cmpWord(rd, 32'h0001_0005);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        cmpBit(err, 1'b1);
        for (i = 0; i < 11; i++) begin
            apb(1'b1, muovr_pkg::CTRL_ADDR, {15'h0000, i != 10, 4'h0, 12'(secs[i])});
            repeat (3) @(posedge clk);
            apb(1'b0, muovr_pkg::COUNT_ADDR, 32'h0000_0000);
            cmpWord(rd & 32'h01FF_0000,
                {7'h00, expLimit(secs[i], i != 10), 16'h0000});
        end
        apb(1'b1, muovr_pkg::CTRL_ADDR, 32'h0001_0005);
        pm.objectIn(4'($random(seed)) | 4'h1);
        repeat (8) @(posedge clk);
        cmpBit(overrideRequest, 1'b1);
        n = 0;
        while (overrideRequest === 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        cmpBit(n >= 240 * SC && n <= 251 * SC, 1'b1);
        repeat (2) begin
            mutingFaultStop <= 1'b1;
            @(posedge clk);
            mutingFaultStop <= 1'b0;
            @(posedge clk);
            cmpBit(overrideRequest, 1'b1);
            repeat (8) @(posedge clk);
            cmpBit(overrideRequest, 1'b0);
        end
        pm.press(50, SC);
        repeat (12) @(posedge clk);
        cmpBit(outputEnable, 1'b0);
        pm.press(3100, SC);
        repeat (12) @(posedge clk);
        cmpBit(outputEnable, 1'b0);
        pm.press(150 + ($random(seed) & 1023), SC);
        repeat (12) @(posedge clk);
        cmpBit(outputEnable, 1'b1);
        cmpBit(overrideActive, 1'b1);
        cmpBit(mutingStatus, 1'b1);
        apb(1'b0, muovr_pkg::COUNT_ADDR, 32'h0000_0000);
        cmpWord(rd & 32'h0000_01FF, 32'h0000_0001);
        pm.objectOut();
        repeat (6) @(posedge clk);
        cmpBit(outputEnable, 1'b0);
        mutingValidEnd <= 1'b1;
        @(posedge clk);
        mutingValidEnd <= 1'b0;
        apb(1'b0, muovr_pkg::COUNT_ADDR, 32'h0000_0000);
        cmpWord(rd & 32'h0000_01FF, 32'h0000_0000);
        apb(1'b1, muovr_pkg::CTRL_ADDR, 32'h0001_0384);
        for (i = 0; i < 5; i++) begin
            pm.objectIn(4'h3);
            repeat (8) @(posedge clk);
            if (i == 4) begin
                pm.press(200, SC);
                repeat (12) @(posedge clk);
                cmpBit(outputEnable, 1'b1);
            end
            pm.objectOut();
            repeat (8) @(posedge clk);
        end
        pm.objectIn(4'h3);
        repeat (8) @(posedge clk);
        cmpBit(overrideExhausted, 1'b1);
        pm.press(200, SC);
        repeat (12) @(posedge clk);
        cmpBit(outputEnable, 1'b0);
        apb(1'b0, muovr_pkg::COUNT_ADDR, 32'h0000_0000);
        cmpWord(rd, 32'h0005_0006);
        pm.objectOut();
        execMode <= 1'b0;
        repeat (4) @(posedge clk);
        execMode <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b0, muovr_pkg::COUNT_ADDR, 32'h0000_0000);
        cmpWord(rd & 32'h0000_01FF, 32'h0000_0000);
        apb(1'b1, muovr_pkg::CTRL_ADDR, 32'h0001_0001);
        pm.conveyor(1'b0);
        repeat (6) @(posedge clk);
        cmpBit(timersHold, 1'b1);
        mutingActive <= 1'b1;
        repeat (1500 * SC) @(posedge clk);
        cmpBit(mutingTimeout, 1'b0);
        pm.conveyor(1'b1);
        repeat (3500 * SC) @(posedge clk);
        cmpBit(mutingTimeout, 1'b0);
        repeat (600 * SC) @(posedge clk);
        cmpBit(mutingTimeout, 1'b1);
        mutingError <= 1'b1;
        repeat (4) @(posedge clk);
        cmpBit(mutingStatus, 1'b0);
        mutingError <= 1'b0;
        repeat (4) @(posedge clk);
        cmpBit(mutingStatus, 1'b1);
        wrap_up();
    end
endmodule // testbench
